// ===== rtl/ocm_monitor.sv
// Output condition monitor: detectors, terminal delay and polarity, scaling.
//
// Added by the designer: the APB register port and the register offsets.
module ocm_monitor #(
  parameter int unsigned TICK_CYCLES = ocm_pkg::OCM_TICK_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ocm_pkg::OCM_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [15:0] i_run_freq,
  input wire logic [15:0] i_target_freq,
  input wire logic [11:0] i_out_current,
  input wire logic [9:0] i_ai1_volts,
  input wire logic [7:0] i_heatsink_temp,
  input wire logic [13:0] i_ao1_std,
  input wire logic [13:0] i_ao2_std,
  input wire logic [13:0] i_pulse_std,
  input wire logic i_pcd_state,
  input wire logic i_relay1_state,
  input wire logic i_do1_state,
  output logic o_freq_level_detector_one,
  output logic o_freq_level_detector_two,
  output logic o_freq_arrive,
  output logic o_fwin1,
  output logic o_fwin2,
  output logic o_cwin1,
  output logic o_cwin2,
  output logic o_ai1_overrun,
  output logic o_temp_reached,
  output logic o_zero_current,
  output logic o_cur_overrun,
  output logic o_pcd_out,
  output logic o_relay1_out,
  output logic o_do1_out,
  output logic [13:0] o_ao1_value,
  output logic [13:0] o_ao2_value,
  output logic o_ao1_current_mode,
  output logic o_ao2_current_mode,
  output logic o_pulse_train,
  output logic [16:0] o_pulse_freq
);
  import ocm_pkg::*;

  function automatic logic [15:0] lim(input logic [15:0] v,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
    lim = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [15:0] slim(input logic [15:0] v);
    logic signed [15:0] s;
    s = v;
    slim = (s < OCM_SLIM_LO) ? OCM_SLIM_LO :
           ((s > OCM_SLIM_HI) ? OCM_SLIM_HI : s);
  endfunction

  function automatic logic [15:0] pct_of(input logic [15:0] base,
                                         input logic [15:0] pct);
    logic [31:0] p;
    p = base * pct;
    pct_of = 16'(p / OCM_PCT_DIV);
  endfunction

  function automatic logic in_window(input logic [15:0] a,
                                     input logic [15:0] c,
                                     input logic [15:0] w);
    logic [15:0] d;
    d = (a >= c) ? a - c : c - a;
    in_window = (d <= w);
  endfunction

  // Out-of-range writes are pulled to the nearest legal value, and mode and polarity writes keep only their low bits, so the
  // datapath never sees a setting it would have to guard against.
  function automatic logic [31:0] clamp_wr(input logic [4:0] i,
                                           input logic [31:0] d);
    logic [15:0] hi;
    logic [15:0] lo;
    hi = d[31:16];
    lo = d[15:0];
    case (i)
      OCM_IDX_PMAX: begin
        hi = 16'h0000;
        lo = lim(d[15:0], OCM_PMAX_MIN, OCM_PMAX_MAX);
      end
      OCM_IDX_AO1, OCM_IDX_AO2: begin
        hi = slim(d[31:16]);
        lo = slim(d[15:0]);
      end
      OCM_IDX_AO_MODE: begin
        hi = 16'h0000;
        lo = {14'h0000, d[1:0]};
      end
      OCM_IDX_DLY_PCD, OCM_IDX_DLY_RLY1, OCM_IDX_DLY_DO1: begin
        hi = 16'h0000;
        lo = lim(d[15:0], 16'h0000, OCM_TDLY_MAX);
      end
      OCM_IDX_POL: begin
        hi = 16'h0000;
        lo = {11'h000, d[OCM_POL_W-1:0]};
      end
      OCM_IDX_FREQ_LEVEL_DETECTOR_ONE, OCM_IDX_FREQ_LEVEL_DETECTOR_TWO: begin
        hi = lim(d[31:16], 16'h0000, OCM_PCT_MAX);
      end
      OCM_IDX_ARRIVE, OCM_IDX_FWIN1, OCM_IDX_FWIN2: begin
        hi = lim(d[31:16], 16'h0000, OCM_PCT_MAX);
      end
      OCM_IDX_CWIN1, OCM_IDX_CWIN2: begin
        hi = lim(d[31:16], 16'h0000, OCM_CUR_MAX);
        lo = lim(d[15:0], 16'h0000, OCM_CUR_MAX);
      end
      OCM_IDX_AI1_LIM: begin
        hi = lim(d[31:16], 16'h0000, OCM_VOLT_MAX);
        lo = lim(d[15:0], 16'h0000, hi);
      end
      OCM_IDX_TEMP: begin
        hi = 16'h0000;
        lo = lim(d[15:0], 16'h0000, OCM_TEMP_MAX);
      end
      OCM_IDX_ZERO, OCM_IDX_OVR: begin
        hi = lim(d[31:16], 16'h0000, OCM_PDLY_MAX);
        lo = lim(d[15:0], 16'h0000, OCM_CUR_MAX);
      end
      default: begin
        hi = 16'h0000;
        lo = 16'h0000;
      end
    endcase
    clamp_wr = {hi, lo};
  endfunction

  logic [31:0] regs_r [0:OCM_NWR-1];
  logic [31:0] prdata_r;
  logic [OCM_TICK_W-1:0] tick_cnt_r;
  logic [1:0] fdt_r;
  logic arrive_r;
  logic [1:0] fwin_r;
  logic [1:0] cwin_r;
  logic ai1_ovr_r;
  logic temp_r;
  logic [1:0] pst_r;
  logic [15:0] pcnt_r [0:1];
  logic [OCM_NTERM-1:0] term_lvl_r;
  logic [OCM_NTERM-1:0] term_out_r;
  logic [19:0] tcnt_r [0:OCM_NTERM-1];
  logic [13:0] ao_r [0:1];
  logic [24:0] acc_r;
  logic pulse_r;
  logic [16:0] pfreq_r;

  // Register bus: zero wait states, read data captured in the setup cycle.
  wire [4:0] idx = i_paddr[6:2];
  wire bus_setup = i_psel & ~i_penable;
  wire bus_access = i_psel & i_penable;
  wire addr_hit = (i_paddr[1:0] == 2'h0) && (idx < 5'(OCM_NREG));
  wire wr_en = bus_access & i_pwrite & addr_hit & (idx < 5'(OCM_NWR));
  wire [31:0] status_word = {17'h00000, term_out_r, 1'b0, pst_r[1], pst_r[0],
    temp_r, ai1_ovr_r, cwin_r, fwin_r, arrive_r, fdt_r};
  wire [31:0] ao_word = {2'h0, ao_r[1], 2'h0, ao_r[0]};
  wire [31:0] rd_data = (idx < 5'(OCM_NWR)) ? regs_r[idx] :
    ((idx == OCM_IDX_STATUS) ? status_word : ao_word);

  assign o_pready = bus_access;
  assign o_pslverr = bus_access & ~addr_hit;
  assign o_prdata = prdata_r;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < OCM_NWR; i++) begin
        regs_r[i] <= OCM_RST[i];
      end
    end else if (wr_en) begin
      regs_r[idx] <= clamp_wr(idx, i_pwdata);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (bus_setup & ~i_pwrite) begin
      prdata_r <= addr_hit ? rd_data : 32'h0000_0000;
    end
  end

  // Shared time base: one tick every ten milliseconds.
  wire tick = (tick_cnt_r == OCM_TICK_W'(TICK_CYCLES - 1));
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // Level and window detectors.
  wire [15:0] maxf = regs_r[OCM_IDX_ARRIVE][15:0];
  wire [15:0] cur = {4'h0, i_out_current};
  wire [15:0] ai1 = {6'h00, i_ai1_volts};
  wire [15:0] band = pct_of(maxf, regs_r[OCM_IDX_ARRIVE][31:16]);
  wire arrive_nxt = in_window(i_run_freq, i_target_freq, band);
  wire [15:0] ai1_lo = regs_r[OCM_IDX_AI1_LIM][15:0];
  wire [15:0] ai1_hi = regs_r[OCM_IDX_AI1_LIM][31:16];
  wire ai1_ovr_nxt = (ai1 > ai1_hi) || (ai1 < ai1_lo);
  wire temp_nxt = i_heatsink_temp >= regs_r[OCM_IDX_TEMP][7:0];
  wire [15:0] ovr_thr = regs_r[OCM_IDX_OVR][15:0];
  wire [1:0] pcond;
  wire [15:0] pdly [0:1];
  assign pcond[0] = cur <= regs_r[OCM_IDX_ZERO][15:0];
  assign pcond[1] = (ovr_thr != 16'h0000) && (cur > ovr_thr);
  assign pdly[0] = regs_r[OCM_IDX_ZERO][31:16];
  assign pdly[1] = regs_r[OCM_IDX_OVR][31:16];

  for (genvar k = 0; k < 2; k++) begin : g_pair
    wire [31:0] fdt_reg = regs_r[OCM_IDX_FREQ_LEVEL_DETECTOR_ONE + 5'(k)];
    wire [31:0] fwin_reg = regs_r[OCM_IDX_FWIN1 + 5'(k)];
    wire [31:0] cwin_reg = regs_r[OCM_IDX_CWIN1 + 5'(k)];
    wire [15:0] lag = pct_of(fdt_reg[15:0], fdt_reg[31:16]);
    wire [15:0] release_at = fdt_reg[15:0] - lag;
    // Set above the level, released only below level minus lag.
    wire fdt_nxt = fdt_r[k] ? !(i_run_freq < release_at)
                            : (i_run_freq > fdt_reg[15:0]);
    wire [15:0] fw = pct_of(maxf, fwin_reg[31:16]);
    wire fwin_nxt = in_window(i_run_freq, fwin_reg[15:0], fw);
    wire cwin_nxt = in_window(cur, cwin_reg[15:0], cwin_reg[31:16]);
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
        fdt_r[k] <= 1'b0;
        fwin_r[k] <= 1'b0;
        cwin_r[k] <= 1'b0;
      end else begin
        fdt_r[k] <= fdt_nxt;
        fwin_r[k] <= fwin_nxt;
        cwin_r[k] <= cwin_nxt;
      end
    end

    // Persistence timer, zero-current for k=0 and overrun for k=1.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
        pcnt_r[k] <= 16'h0000;
        pst_r[k] <= 1'b0;
      end else begin
        if (!pcond[k]) begin
          pcnt_r[k] <= 16'h0000;
        end else if (tick && pcnt_r[k] != 16'hFFFF) begin
          pcnt_r[k] <= pcnt_r[k] + 16'h0001;
        end
        pst_r[k] <= pcond[k] && (pcnt_r[k] >= pdly[k]);
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      arrive_r <= 1'b0;
      ai1_ovr_r <= 1'b0;
      temp_r <= 1'b0;
    end else begin
      arrive_r <= arrive_nxt;
      ai1_ovr_r <= ai1_ovr_nxt;
      temp_r <= temp_nxt;
    end
  end

  // Output terminals: delayed state change, then selectable polarity.
  wire [OCM_NTERM-1:0] term_in = {i_do1_state, i_relay1_state, i_pcd_state};
  wire [OCM_POL_W-1:0] pol = regs_r[OCM_IDX_POL][OCM_POL_W-1:0];
  for (genvar j = 0; j < OCM_NTERM; j++) begin : g_term
    wire [15:0] dly = regs_r[OCM_IDX_DLY_PCD + 5'(j)][15:0];
    wire [19:0] dly_ticks = 20'(dly * OCM_TERM_TICKS_PER_UNIT);
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
        term_lvl_r[j] <= 1'b0;
        tcnt_r[j] <= 20'h00000;
        term_out_r[j] <= 1'b0;
      end else begin
        // A change that reverts before the delay runs out never shows.
        if (term_in[j] == term_lvl_r[j]) begin
          tcnt_r[j] <= 20'h00000;
        end else if (tcnt_r[j] >= dly_ticks) begin
          term_lvl_r[j] <= term_in[j];
          tcnt_r[j] <= 20'h00000;
        end else if (tick) begin
          tcnt_r[j] <= tcnt_r[j] + 20'h00001;
        end
        term_out_r[j] <= term_lvl_r[j] ^ pol[OCM_POL_POS[j]];
      end
    end
  end

  // Analog channels: y = k * x + b * full scale, clipped to the range.
  wire [13:0] ao_std [0:1];
  assign ao_std[0] = i_ao1_std;
  assign ao_std[1] = i_ao2_std;
  for (genvar c = 0; c < 2; c++) begin : g_ao
    wire [31:0] ao_reg = regs_r[OCM_IDX_AO1 + 5'(c)];
    wire signed [15:0] gain = ao_reg[31:16];
    wire signed [15:0] ofs = ao_reg[15:0];
    wire signed [14:0] xs = {1'b0, ao_std[c]};
    wire signed [30:0] prod = xs * gain;
    wire signed [31:0] y = 32'(prod / OCM_GAIN_DIV)
      + 32'(ofs * OCM_OFS_SCALE);
    wire [13:0] y_clip = (y < 0) ? 14'h0000 :
      ((y > OCM_AO_FULL) ? 14'(OCM_AO_FULL) : y[13:0]);
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
        ao_r[c] <= 14'h0000;
      end else begin
        ao_r[c] <= y_clip;
      end
    end
  end

  assign o_ao1_value = ao_r[0];
  assign o_ao2_value = ao_r[1];
  // The mode bit only selects the 10 V or 20 mA driver; the code is shared.
  assign o_ao1_current_mode = regs_r[OCM_IDX_AO_MODE][0];
  assign o_ao2_current_mode = regs_r[OCM_IDX_AO_MODE][1];

  // Pulse train: full-scale input maps to the configured maximum.
  wire [31:0] pprod = regs_r[OCM_IDX_PMAX][13:0] * i_pulse_std;
  wire [16:0] pfreq_nxt = 17'(pprod / OCM_PULSE_DIV);
  wire [25:0] acc_sum = {1'b0, acc_r} + {8'h00, pfreq_r, 1'b0};
  wire acc_wrap = acc_sum >= 26'(OCM_CLK_HZ);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pfreq_r <= 17'h00000;
      acc_r <= 25'h0000000;
      pulse_r <= 1'b0;
    end else begin
      pfreq_r <= pfreq_nxt;
      acc_r <= acc_wrap ? 25'(acc_sum - 26'(OCM_CLK_HZ)) : acc_sum[24:0];
      pulse_r <= pulse_r ^ acc_wrap;
    end
  end

  assign o_pulse_train = pulse_r;
  assign o_pulse_freq = pfreq_r;
  assign o_freq_level_detector_one = fdt_r[0];
  assign o_freq_level_detector_two = fdt_r[1];
  assign o_freq_arrive = arrive_r;
  assign o_fwin1 = fwin_r[0];
  assign o_fwin2 = fwin_r[1];
  assign o_cwin1 = cwin_r[0];
  assign o_cwin2 = cwin_r[1];
  assign o_ai1_overrun = ai1_ovr_r;
  assign o_temp_reached = temp_r;
  assign o_zero_current = pst_r[0];
  assign o_cur_overrun = pst_r[1];
  assign o_pcd_out = term_out_r[0];
  assign o_relay1_out = term_out_r[1];
  assign o_do1_out = term_out_r[2];
endmodule

// ===== rtl/ocm_pkg.sv
// Constants, register map and reset values of the output condition monitor.
package ocm_pkg;
  localparam int unsigned OCM_CLK_HZ = 25_000_000;
  localparam int unsigned OCM_TICK_MS = 10;
  localparam int unsigned OCM_TICK_CYCLES = OCM_CLK_HZ / 1000 * OCM_TICK_MS;
  localparam int unsigned OCM_TICK_W = 18;
  localparam int unsigned OCM_TERM_TICKS_PER_UNIT = 100 / OCM_TICK_MS;
  localparam int unsigned OCM_AW = 7;
  localparam int unsigned OCM_NWR = 19;
  localparam int unsigned OCM_NREG = 21;
  localparam int unsigned OCM_NTERM = 3;
  // Register indices; the byte address is four times the index.
  localparam logic [4:0] OCM_IDX_PMAX = 5'h00;
  localparam logic [4:0] OCM_IDX_AO1 = 5'h01;
  localparam logic [4:0] OCM_IDX_AO2 = 5'h02;
  localparam logic [4:0] OCM_IDX_AO_MODE = 5'h03;
  localparam logic [4:0] OCM_IDX_DLY_PCD = 5'h04;
  localparam logic [4:0] OCM_IDX_DLY_RLY1 = 5'h05;
  localparam logic [4:0] OCM_IDX_DLY_DO1 = 5'h06;
  localparam logic [4:0] OCM_IDX_POL = 5'h07;
  localparam logic [4:0] OCM_IDX_FREQ_LEVEL_DETECTOR_ONE = 5'h08;
  localparam logic [4:0] OCM_IDX_FREQ_LEVEL_DETECTOR_TWO = 5'h09;
  localparam logic [4:0] OCM_IDX_ARRIVE = 5'h0A;
  localparam logic [4:0] OCM_IDX_FWIN1 = 5'h0B;
  localparam logic [4:0] OCM_IDX_FWIN2 = 5'h0C;
  localparam logic [4:0] OCM_IDX_CWIN1 = 5'h0D;
  localparam logic [4:0] OCM_IDX_CWIN2 = 5'h0E;
  localparam logic [4:0] OCM_IDX_AI1_LIM = 5'h0F;
  localparam logic [4:0] OCM_IDX_TEMP = 5'h10;
  localparam logic [4:0] OCM_IDX_ZERO = 5'h11;
  localparam logic [4:0] OCM_IDX_OVR = 5'h12;
  localparam logic [4:0] OCM_IDX_STATUS = 5'h13;
  localparam logic [4:0] OCM_IDX_AO_OUT = 5'h14;
  // Reset values.
  localparam logic [31:0] OCM_RST_PMAX = 32'h0000_1388;
  localparam logic [31:0] OCM_RST_AO = 32'h0064_0000;
  localparam logic [31:0] OCM_RST_ZEROS = 32'h0000_0000;
  localparam logic [31:0] OCM_RST_FDT = 32'h0032_1388;
  localparam logic [31:0] OCM_RST_ARRIVE = 32'h0000_1388;
  localparam logic [31:0] OCM_RST_FWIN = 32'h0000_1388;
  localparam logic [31:0] OCM_RST_CWIN = 32'h0000_03E8;
  localparam logic [31:0] OCM_RST_AI1_LIM = 32'h02A8_0136;
  localparam logic [31:0] OCM_RST_TEMP = 32'h0000_004B;
  localparam logic [31:0] OCM_RST_ZERO = 32'h000A_0032;
  localparam logic [31:0] OCM_RST_OVR = 32'h0000_07D0;
  localparam logic [31:0] OCM_RST [0:OCM_NWR-1] = '{
    OCM_RST_PMAX, OCM_RST_AO, OCM_RST_AO, OCM_RST_ZEROS, OCM_RST_ZEROS,
    OCM_RST_ZEROS, OCM_RST_ZEROS, OCM_RST_ZEROS, OCM_RST_FDT, OCM_RST_FDT,
    OCM_RST_ARRIVE, OCM_RST_FWIN, OCM_RST_FWIN, OCM_RST_CWIN, OCM_RST_CWIN,
    OCM_RST_AI1_LIM, OCM_RST_TEMP, OCM_RST_ZERO, OCM_RST_OVR};
  // Field limits, in the units of each field.
  localparam logic [15:0] OCM_PMAX_MIN = 16'h0001;
  localparam logic [15:0] OCM_PMAX_MAX = 16'h2710;
  localparam logic signed [15:0] OCM_SLIM_HI = 16'sh03E8;
  localparam logic signed [15:0] OCM_SLIM_LO = -16'sh03E8;
  localparam logic [15:0] OCM_TDLY_MAX = 16'h8CA0;
  localparam logic [15:0] OCM_PCT_MAX = 16'h03E8;
  localparam logic [15:0] OCM_CUR_MAX = 16'h0BB8;
  localparam logic [15:0] OCM_VOLT_MAX = 16'h03E8;
  localparam logic [15:0] OCM_TEMP_MAX = 16'h0064;
  localparam logic [15:0] OCM_PDLY_MAX = 16'hEA60;
  localparam logic [31:0] OCM_PCT_DIV = 32'h0000_03E8;
  localparam logic signed [31:0] OCM_AO_FULL = 32'sh0000_2710;
  localparam logic signed [30:0] OCM_GAIN_DIV = 31'sh0000_0064;
  localparam logic signed [15:0] OCM_OFS_SCALE = 16'sh000A;
  localparam logic [31:0] OCM_PULSE_DIV = 32'h0000_03E8;
  localparam int unsigned OCM_POL_W = 5;
  localparam int unsigned OCM_POL_POS [0:OCM_NTERM-1] = '{0, 1, 3};
endpackage

// ===== verif/ocm_monitor_sva.sv
// Property checker for the output condition monitor.
module ocm_monitor_sva #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ocm_pkg::OCM_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [15:0] i_run_freq,
  input wire logic [11:0] i_out_current,
  input wire logic [9:0] i_ai1_volts,
  input wire logic [7:0] i_heatsink_temp,
  input wire logic i_do1_state,
  input wire logic o_freq_level_detector_one,
  input wire logic o_cwin1,
  input wire logic o_ai1_overrun,
  input wire logic o_temp_reached,
  input wire logic o_zero_current,
  input wire logic o_cur_overrun,
  input wire logic o_do1_out
);
  import ocm_pkg::*;
  logic [31:0] sh_r [0:OCM_NWR-1];
  logic [1:0] live_r;
  int zc_r;
  logic live, wr_hit, ai_bad, tmp_hit, cw_in, run_gt, run_lt;
  logic z_cond, ov_cond, zc_ok, pol3;
  int cur, ct, cwd, lvl;
  // Shadow words mirror APB writes; only legal values reach the words used.
  assign live = live_r == 2'h2;
  assign wr_hit = i_psel && i_penable && i_pwrite && i_paddr[1:0] == 2'h0
    && i_paddr[6:2] < 5'h13;
  assign cur = int'(i_out_current);
  assign lvl = int'(sh_r[8][15:0]);
  assign ct = int'(sh_r[13][15:0]);
  assign cwd = int'(sh_r[13][31:16]);
  assign pol3 = sh_r[7][3];
  assign ai_bad = {6'h0, i_ai1_volts} > sh_r[15][31:16]
    || {6'h0, i_ai1_volts} < sh_r[15][15:0];
  assign tmp_hit = i_heatsink_temp >= sh_r[16][7:0];
  assign cw_in = cur >= ct - cwd && cur <= ct + cwd;
  assign run_gt = int'(i_run_freq) > lvl;
  assign run_lt = int'(i_run_freq) < lvl - lvl * int'(sh_r[8][31:16]) / 1000;
  assign z_cond = cur <= int'(sh_r[17][15:0]);
  assign ov_cond = sh_r[18][15:0] != 16'h0 && cur > int'(sh_r[18][15:0]);
  // Two ticks of slack, since the free-running tick phase is unknown.
  assign zc_ok = zc_r + 2 * TICK_CYCLES > int'(sh_r[17][31:16]) * TICK_CYCLES;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sh_r <= OCM_RST;
      live_r <= 2'h0;
      zc_r <= 0;
    end else begin
      if (wr_hit) begin
        sh_r[i_paddr[6:2]] <= i_pwdata;
      end
      if (!live) begin
        live_r <= live_r + 2'h1;
      end
      zc_r <= z_cond ? zc_r + 1 : 0;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  property p_ai1_ovr;
    live |-> o_ai1_overrun == $past(ai_bad);
  endproperty
  a_ai1_ovr: assert property (p_ai1_ovr)
    else $error("ai1 overrun flag disagrees with limits");
  property p_temp;
    live |-> o_temp_reached == $past(tmp_hit);
  endproperty
  a_temp: assert property (p_temp)
    else $error("temperature flag disagrees with threshold");
  property p_cwin1;
    live |-> o_cwin1 == $past(cw_in);
  endproperty
  a_cwin1: assert property (p_cwin1)
    else $error("current window flag wrong");
  property p_fdt_set;
    live && $rose(o_freq_level_detector_one) |-> $past(run_gt);
  endproperty
  a_fdt_set: assert property (p_fdt_set)
    else $error("level detector set without exceeding level");
  property p_fdt_clr;
    live && $fell(o_freq_level_detector_one) |-> $past(run_lt);
  endproperty
  a_fdt_clr: assert property (p_fdt_clr)
    else $error("level detector released inside lag band");
  property p_zero;
    $rose(o_zero_current) |-> zc_ok;
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero current flag rose before its delay");
  property p_zero_lvl;
    live && o_zero_current |-> $past(z_cond);
  endproperty
  a_zero_lvl: assert property (p_zero_lvl)
    else $error("zero current flag while above level");
  property p_ovr;
    live && o_cur_overrun |-> $past(ov_cond);
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("overrun flag without overrun");
  property p_do1;
    live && sh_r[6][15:0] == 16'h0 && $stable(i_do1_state)
      && $past(i_do1_state, 2) == i_do1_state && $stable(pol3)
      && $past(pol3, 2) == pol3 |-> o_do1_out == (i_do1_state ^ pol3);
  endproperty
  a_do1: assert property (p_do1)
    else $error("terminal contact disagrees with state and polarity");
endmodule

bind ocm_monitor ocm_monitor_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .i_run_freq(i_run_freq),
  .i_out_current(i_out_current), .i_ai1_volts(i_ai1_volts),
  .i_heatsink_temp(i_heatsink_temp), .i_do1_state(i_do1_state),
  .o_freq_level_detector_one(o_freq_level_detector_one), .o_cwin1(o_cwin1), .o_ai1_overrun(o_ai1_overrun),
  .o_temp_reached(o_temp_reached), .o_zero_current(o_zero_current),
  .o_cur_overrun(o_cur_overrun), .o_do1_out(o_do1_out));

// ===== verif/tb_top.sv
// Self-checking bench for the output condition monitor.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ocm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [6:0] paddr = '0;
  logic [31:0] pwdata = '0, rv, prdata;
  logic re, pready, pslverr, m1, m2, ptr, pv;
  logic [15:0] run = '0, tgt = '0;
  logic [11:0] cur = '0;
  logic [9:0] ai = '0;
  logic [7:0] tmp = '0;
  logic [13:0] x1 = '0, x2 = '0, xp = '0, ao1, ao2;
  logic [16:0] pf;
  logic [2:0] st = '0;
  wire [10:0] fl;
  wire [2:0] to;
  int err_count = 0, checks_done = 0, s1 = 0, s2 = 0, g, o, a1, a2, pm;
  int f1l = 5000, f1g = 50, f2l = 5000, f2g = 50, ab = 0, w1v = 5000;
  int w1w = 0, c1w = 0, tc;
  logic [31:0] clw [3] = '{32'h0, 32'hFFFF, 32'h07D0_F830};
  logic [31:0] cle [3] = '{32'h1, 32'h2710, 32'h03E8_FC18};
  logic [6:0] cla [3] = '{7'h00, 7'h00, 7'h04};
  int ga [5] = '{100, -50, 1000, -1000, 37};
  int oa [5] = '{0, 800, -1000, 1000, -250};
  int sv [8][5] = '{'{5001, 3000, 899, 309, 74}, '{4800, 4750, 900, 310, 75},
    '{4749, 4749, 1100, 680, 100}, '{3500, 3100, 1101, 681, 0},
    '{2500, 2400, 1000, 500, 50}, '{2499, 5000, 0, 0, 255},
    '{5000, 5000, 3000, 1000, 20}, '{1799, 1700, 1500, 400, 80}};
  ocm_monitor #(.TICK_CYCLES(4)) uut (
    .i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_run_freq(run),
    .i_target_freq(tgt), .i_out_current(cur), .i_ai1_volts(ai),
    .i_heatsink_temp(tmp), .i_ao1_std(x1), .i_ao2_std(x2), .i_pulse_std(xp),
    .i_pcd_state(st[0]), .i_relay1_state(st[1]), .i_do1_state(st[2]),
    .o_freq_level_detector_one(fl[0]), .o_freq_level_detector_two(fl[1]), .o_freq_arrive(fl[2]), .o_fwin1(fl[3]),
    .o_fwin2(fl[4]), .o_cwin1(fl[5]), .o_cwin2(fl[6]),
    .o_ai1_overrun(fl[7]), .o_temp_reached(fl[8]),
    .o_zero_current(fl[9]), .o_cur_overrun(fl[10]), .o_pcd_out(to[0]),
    .o_relay1_out(to[1]), .o_do1_out(to[2]), .o_ao1_value(ao1),
    .o_ao2_value(ao2), .o_ao1_current_mode(m1), .o_ao2_current_mode(m2),
    .o_pulse_train(ptr), .o_pulse_freq(pf));
  always #20 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors=%0d checks=%0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Zero wait states are expected, but the wait stays bounded anyway.
  task automatic apb(input logic w, input logic [6:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) begin
      err_count++;
      complete_run();
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  function automatic int win(int v, int c, int w);
    return v >= c - w && v <= c + w;
  endfunction
  function automatic int aoexp(int g, int o, int x);
    int y = g * x / 100 + o * 10;
    return y < 0 ? 0 : (y > 10000 ? 10000 : y);
  endfunction
  task automatic stat(input int r, t, c, a, h);
    int e;
    @(posedge clk);
    run <= 16'(r);
    tgt <= 16'(t);
    cur <= 12'(c);
    ai <= 10'(a);
    tmp <= 8'(h);
    if (r > f1l) s1 = 1;
    else if (r < f1l - f1l * f1g / 1000) s1 = 0;
    if (r > f2l) s2 = 1;
    else if (r < f2l - f2l * f2g / 1000) s2 = 0;
    e = s1 | s2 << 1 | win(r, t, 5 * ab) << 2 | win(r, w1v, 5 * w1w) << 3
      | win(r, 5000, 0) << 4 | win(c, 1000, c1w) << 5 | win(c, 1000, 0) << 6
      | int'(a > 680 || a < 310) << 7 | int'(h >= 75) << 8;
    cyc(3);
    chk(32'(fl[8:0]), 32'(e));
  endtask
  initial begin
    void'($urandom(63230));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < OCM_NWR; i++) begin
      apb(1'b0, 7'(i * 4), '0);
      chk(rv, OCM_RST[i]);
    end
    apb(1'b0, 7'h54, '0);
    chk({rv[30:0], re}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, cla[i], clw[i]);
      apb(1'b0, cla[i], '0);
      chk(rv, cle[i]);
    end
    for (int i = 0; i < 4; i++) begin
      pm = i == 0 ? 10000 : $urandom_range(10000, 1);
      a1 = i == 0 ? 10000 : $urandom_range(10000, 0);
      apb(1'b1, 7'h00, 32'(pm));
      xp <= 14'(a1);
      cyc(3);
      chk(32'(pf), 32'(pm * a1 / 1000));
    end
    // At 100 kHz the wave toggles exactly once every 125 clocks.
    apb(1'b1, 7'h00, 32'h0000_2710);
    xp <= 14'h2710;
    cyc(3);
    pv = ptr;
    tc = 0;
    repeat (1250) begin
      @(posedge clk);
      tc += int'(ptr != pv);
      pv = ptr;
    end
    chk(32'(tc), 32'hA);
    apb(1'b1, 7'h0C, 32'h3);
    for (int i = 0; i < 5; i++) begin
      g = ga[i];
      o = oa[i];
      a1 = i == 1 ? 10000 : $urandom_range(10000, 0);
      a2 = i == 1 ? 0 : $urandom_range(10000, 0);
      apb(1'b1, 7'h04, {16'(g), 16'(o)});
      apb(1'b1, 7'h08, {16'(g), 16'(o)});
      x1 <= 14'(a1);
      x2 <= 14'(a2);
      cyc(3);
      chk(32'(ao1), 32'(aoexp(g, o, a1)));
      chk(32'(ao2), 32'(aoexp(g, o, a2)));
    end
    apb(1'b0, 7'h50, '0);
    chk(rv, 32'(aoexp(g, o, a2)) << 16 | 32'(aoexp(g, o, a1)));
    chk({30'h0, m2, m1}, 32'h3);
    apb(1'b1, 7'h28, {16'd20, 16'd5000});
    ab = 20;
    apb(1'b1, 7'h2C, {16'd100, 16'd3000});
    w1v = 3000;
    w1w = 100;
    apb(1'b1, 7'h34, {16'd100, 16'd1000});
    c1w = 100;
    apb(1'b1, 7'h24, {16'd100, 16'd2000});
    f2l = 2000;
    f2g = 100;
    foreach (sv[i]) stat(sv[i][0], sv[i][1], sv[i][2], sv[i][3], sv[i][4]);
    cur <= 12'd100;
    cyc(3);
    cur <= 12'd50;
    cyc(30);
    cur <= 12'd51;
    cyc(1);
    cur <= 12'd50;
    cyc(30);
    chk(32'(fl[9]), 32'h0);
    cyc(20);
    chk(32'(fl[9]), 32'h1);
    apb(1'b1, 7'h48, {16'd5, 16'd1500});
    cur <= 12'd1501;
    cyc(8);
    chk(32'(fl[10]), 32'h0);
    cyc(30);
    chk(32'(fl[10]), 32'h1);
    apb(1'b1, 7'h48, {16'd5, 16'd0});
    cyc(3);
    chk(32'(fl[10]), 32'h0);
    apb(1'b1, 7'h1C, 32'h0A);
    apb(1'b0, 7'h1C, '0);
    chk(rv, 32'h0A);
    apb(1'b1, 7'h14, 32'h1);
    cyc(60);
    chk(32'(to), 32'h6);
    st <= 3'h7;
    cyc(20);
    chk(32'(to), 32'h3);
    cyc(40);
    chk(32'(to), 32'h1);
    st <= 3'h5;
    cyc(20);
    st <= 3'h7;
    cyc(40);
    chk(32'(to), 32'h1);
    apb(1'b0, 7'h4C, '0);
    chk(32'(rv[14:9]), 32'h08);
    complete_run();
  end
endmodule
